/* File: hw/tpg_pkg.sv */
// Constants, register map and field layout of the thermal power guard.
package tpg_pkg;
    // Core clock period in nanoseconds.
    localparam int CLK_PERIOD_NS = 10;
    // Hot pin must hold a new level for longer than this time.
    localparam int HOT_FILT_NS = 10;
    // Least time, strictly longer: one cycle beyond the rounded-up count.
    localparam int HOT_FILT_CYC = (HOT_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    // Length of one throttling period in nanoseconds.
    localparam int THROTTLE_PERIOD_NS = 6000;
    // Throttling period in cycles.
    localparam int THROTTLE_PERIOD_CYC = THROTTLE_PERIOD_NS / CLK_PERIOD_NS;
    // Part of each period during which the core clock is ramped down.
    localparam int THROTTLE_DOWN_CYC = THROTTLE_PERIOD_CYC / 2;
    // Width of the throttle period counter.
    localparam int THR_CNT_W = 10;
    // Width of the hot pin filter counter.
    localparam int FILT_CNT_W = 2;
    // Temperature reading width.
    localparam int TEMP_W = 8;
    // Voltage select code that picks the startup core voltage; value is arbitrary.
    localparam logic [5:0] STARTUP_VID = 6'h12;
    // Register byte offsets.
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_THRESH = 12'h004;
    localparam logic [11:0] ADDR_TRIP = 12'h008;
    localparam logic [11:0] ADDR_STATUS = 12'h00c;
    // Control register fields.
    localparam int CTRL_THR_EN = 0;
    localparam int CTRL_IRQ_ROUTE = 1;
    localparam int CTRL_SBC_EN = 2;
    localparam int CTRL_STC_EN = 3;
    localparam int CTRL_DIV_LSB = 4;
    localparam int CTRL_DIV_W = 4;
    // Threshold register fields.
    localparam int TH_LIMIT_LSB = 0;
    localparam int TH_HYST_LSB = 8;
    localparam int TH_HIGH_LSB = 16;
    localparam int TH_LOW_LSB = 24;
    // Status register fields.
    localparam int ST_TEMP_LSB = 0;
    localparam int ST_THR_ACT = 8;
    localparam int ST_TRIP = 9;
    localparam int ST_HOT_IN = 10;
    localparam int ST_HIGH_SEEN = 11;
    localparam int ST_MEMCLK = 12;
    // Reset values.
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] THRESH_RESET = 32'h0000_0000;
    localparam logic [31:0] TRIP_RESET = 32'h0000_00ff;
    // Bus responses.
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* File: hw/tpg_top.sv */
// Thermal power guard: power-good, reset and thermal protection control.
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module tpg_top
    import tpg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic power_good_in,
    input wire logic chip_reset_n,
    input wire logic c3_state_in,
    input wire logic [TEMP_W-1:0] sensor_a_temp,
    input wire logic [TEMP_W-1:0] sensor_b_temp,
    input wire logic hot_pin_n_in,
    output logic hot_pin_n_out,
    output logic hot_pin_n_oe,
    output logic thermtrip_n,
    output logic internal_clk_stop,
    output logic core_low_power,
    output logic core_clock_grid_en,
    output logic nb_clock_grid_en,
    output logic mem_pins_oe,
    output logic mem_cke,
    output logic mem_reset_n,
    output logic mem_clk_oe,
    output logic mem_clk_p,
    output logic mem_clk_n,
    output logic [5:0] voltage_select_code,
    output logic lvt_thermal_irq,
    output logic stc_bus_cycle,
    output logic htc_enter_cycle,
    output logic htc_exit_cycle,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // Merge a bus write into a register honouring byte strobes.
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Software registers.
    logic [31:0] ctrl_reg;
    logic [31:0] thresh_reg;
    logic [31:0] trip_reg;
    // Write channel state.
    logic aw_held_reg;
    logic [11:0] aw_addr_reg;
    logic w_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    // Read channel state.
    logic arready_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    // Thermal state.
    logic [TEMP_W-1:0] temp_reg;
    logic high_seen_reg;
    logic throttle_reg;
    logic trip_latch_reg;
    logic [THR_CNT_W-1:0] thr_cnt_reg;
    logic hot_filt_reg;
    logic hot_cand_reg;
    logic [FILT_CNT_W-1:0] filt_cnt_reg;
    // Pin state.
    logic mem_clk_on_reg;
    logic [CTRL_DIV_W-1:0] div_cnt_reg;
    logic mem_clk_reg;
    logic hot_oe_reg;
    logic irq_reg;
    logic stc_cyc_reg;
    logic enter_cyc_reg;
    logic exit_cyc_reg;
    logic [5:0] vid_reg;
    logic mem_oe_reg;
    logic cke_reg;
    logic mrst_reg;
    logic low_pwr_reg;
    logic core_en_reg;
    logic clk_stop_reg;

    // Handshakes and write decode.
    wire aw_take = s_axi_awvalid & awready_reg;
    wire w_take = s_axi_wvalid & wready_reg;
    wire ar_take = s_axi_arvalid & arready_reg;
    wire do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
    wire wr_ctrl = do_write & (aw_addr_reg == ADDR_CTRL);
    wire wr_thresh = do_write & (aw_addr_reg == ADDR_THRESH);
    wire wr_trip = do_write & (aw_addr_reg == ADDR_TRIP);
    // Status is read-only, so writes to it are answered as errors too.
    wire wr_ok = wr_ctrl | wr_thresh | wr_trip;
    wire aw_held_next = aw_take | (aw_held_reg & ~do_write);
    wire w_held_next = w_take | (w_held_reg & ~do_write);
    wire bvalid_next = do_write | (bvalid_reg & ~s_axi_bready);
    wire rvalid_next = ar_take | (rvalid_reg & ~s_axi_rready);

    // Configuration fields.
    wire throttle_enable = ctrl_reg[CTRL_THR_EN];
    wire irq_route_bus = ctrl_reg[CTRL_IRQ_ROUTE];
    wire sbc_enable = ctrl_reg[CTRL_SBC_EN];
    wire stc_enable = ctrl_reg[CTRL_STC_EN];
    wire [CTRL_DIV_W-1:0] mem_clk_div = ctrl_reg[CTRL_DIV_LSB +: CTRL_DIV_W];
    wire [TEMP_W-1:0] htc_limit = thresh_reg[TH_LIMIT_LSB +: TEMP_W];
    wire [TEMP_W-1:0] htc_hyst = thresh_reg[TH_HYST_LSB +: TEMP_W];
    wire [TEMP_W-1:0] stc_high = thresh_reg[TH_HIGH_LSB +: TEMP_W];
    wire [TEMP_W-1:0] stc_low = thresh_reg[TH_LOW_LSB +: TEMP_W];
    wire [TEMP_W-1:0] trip_point = trip_reg[TEMP_W-1:0];
    // Strobed trip word; only its low byte is kept.
    wire [31:0] trip_merged = merge_bytes(trip_reg, w_data_reg, w_strb_reg);

    // Read decode.
    wire [31:0] status_word = {19'h0, mem_clk_on_reg, high_seen_reg, hot_filt_reg,
                               trip_latch_reg, throttle_reg, temp_reg};
    wire rd_hit = (s_axi_araddr == ADDR_CTRL) | (s_axi_araddr == ADDR_THRESH) |
                  (s_axi_araddr == ADDR_TRIP) | (s_axi_araddr == ADDR_STATUS);
    wire [31:0] rd_word = (s_axi_araddr == ADDR_CTRL) ? ctrl_reg :
                          (s_axi_araddr == ADDR_THRESH) ? thresh_reg :
                          (s_axi_araddr == ADDR_TRIP) ? trip_reg :
                          (s_axi_araddr == ADDR_STATUS) ? status_word : 32'h0000_0000;

    // Power and reset qualifiers.
    wire run_ok = power_good_in & chip_reset_n;
    // The hotter of the two readings is the working temperature.
    wire [TEMP_W-1:0] temp_next = (sensor_a_temp > sensor_b_temp) ? sensor_a_temp :
                                  sensor_b_temp;
    // Limit comparisons on the registered reading; the hysteresis sum is widened against overflow.
    wire over_limit = temp_reg > htc_limit;
    wire below_hyst = ({1'b0, temp_reg} + {1'b0, htc_hyst}) < {1'b0, htc_limit};
    wire over_trip = temp_reg > trip_point;
    wire over_high = temp_reg > stc_high;
    wire under_low = temp_reg < stc_low;

    // Hot pin filter: a level counts only after HOT_FILT_CYC equal samples.
    wire hot_same = (hot_pin_n_in == hot_cand_reg);
    wire filt_done = hot_same & (filt_cnt_reg == FILT_CNT_W'(HOT_FILT_CYC - 1));
    // While this end drives the pin the level seen is its own, so it is masked.
    wire hot_in = ~hot_filt_reg & ~trip_latch_reg & run_ok & throttle_enable &
                  ~hot_oe_reg;

    // Software thermal interrupt events.
    wire stc_rise = ~high_seen_reg & over_high;
    wire stc_fall = high_seen_reg & under_low;
    wire stc_event = stc_enable & run_ok & (stc_rise | stc_fall);

    // Hardware throttling state transitions.
    wire thr_enter = ~throttle_reg & run_ok & ~c3_state_in & ~trip_latch_reg &
                     (over_limit | hot_in);
    wire thr_exit = throttle_reg & (~run_ok | (below_hyst & ~hot_in));
    wire throttle_next = thr_enter | (throttle_reg & ~thr_exit);
    wire thr_wrap = (thr_cnt_reg == THR_CNT_W'(THROTTLE_PERIOD_CYC - 1));
    wire thr_down = throttle_reg & (thr_cnt_reg < THR_CNT_W'(THROTTLE_DOWN_CYC));

    // Thermal trip: set while valid and over the point, cleared only by chip reset.
    wire trip_next = chip_reset_n & (trip_latch_reg | (run_ok & over_trip));

    // Memory clock gating and divider.
    wire mem_clk_next_on = run_ok & (mem_clk_on_reg | (mem_clk_div != '0));
    wire div_wrap = (div_cnt_reg >= mem_clk_div);

    // Register file writes.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_RESET;
            thresh_reg <= THRESH_RESET;
            trip_reg <= TRIP_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= merge_bytes(ctrl_reg, w_data_reg, w_strb_reg);
            end
            if (wr_thresh) begin
                thresh_reg <= merge_bytes(thresh_reg, w_data_reg, w_strb_reg);
            end
            if (wr_trip) begin
                trip_reg <= {24'h0, trip_merged[TEMP_W-1:0]};
            end
        end
    end

    // Write address and data capture, in either order.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 12'h000;
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else begin
            aw_held_reg <= aw_held_next;
            w_held_reg <= w_held_next;
            if (aw_take) begin
                aw_addr_reg <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
        end
    end

    // Write response and channel readiness.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else begin
            awready_reg <= ~aw_held_next & ~bvalid_next;
            wready_reg <= ~w_held_next & ~bvalid_next;
            bvalid_reg <= bvalid_next;
            if (do_write) begin
                bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // Read channel: data is captured in the cycle the address is taken.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end else begin
            arready_reg <= ~rvalid_next;
            rvalid_reg <= rvalid_next;
            if (ar_take) begin
                rdata_reg <= rd_word;
                rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // Temperature sample and hot pin filter.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            temp_reg <= '0;
            hot_cand_reg <= 1'b1;
            hot_filt_reg <= 1'b1;
            filt_cnt_reg <= '0;
        end else begin
            temp_reg <= temp_next;
            if (!hot_same) begin
                hot_cand_reg <= hot_pin_n_in;
                filt_cnt_reg <= '0;
            end else if (filt_done) begin
                hot_filt_reg <= hot_cand_reg;
            end else begin
                filt_cnt_reg <= filt_cnt_reg + FILT_CNT_W'(1);
            end
        end
    end

    // Thermal state: interrupt history, throttling and trip latch.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            high_seen_reg <= 1'b0;
            throttle_reg <= 1'b0;
            thr_cnt_reg <= '0;
            trip_latch_reg <= 1'b0;
        end else begin
            if (stc_rise) begin
                high_seen_reg <= 1'b1;
            end else if (stc_fall) begin
                high_seen_reg <= 1'b0;
            end
            throttle_reg <= throttle_next;
            if (!throttle_next || thr_enter || thr_wrap) begin
                thr_cnt_reg <= '0;
            end else begin
                thr_cnt_reg <= thr_cnt_reg + THR_CNT_W'(1);
            end
            trip_latch_reg <= trip_next;
        end
    end

    // Event pulses toward the interrupt controller and the I/O hub.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_reg <= 1'b0;
            stc_cyc_reg <= 1'b0;
            enter_cyc_reg <= 1'b0;
            exit_cyc_reg <= 1'b0;
        end else begin
            irq_reg <= stc_event & ~irq_route_bus;
            stc_cyc_reg <= stc_event & irq_route_bus;
            enter_cyc_reg <= sbc_enable & thr_enter;
            exit_cyc_reg <= sbc_enable & thr_exit;
        end
    end

    // Memory clock enable and divided toggle.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mem_clk_on_reg <= 1'b0;
            div_cnt_reg <= '0;
            mem_clk_reg <= 1'b0;
        end else begin
            mem_clk_on_reg <= mem_clk_next_on;
            if (!mem_clk_on_reg || div_wrap) begin
                div_cnt_reg <= '0;
            end else begin
                div_cnt_reg <= div_cnt_reg + CTRL_DIV_W'(1);
            end
            if (!mem_clk_on_reg) begin
                mem_clk_reg <= 1'b0;
            end else if (div_wrap) begin
                mem_clk_reg <= ~mem_clk_reg;
            end
        end
    end

    // Pin and clock control outputs.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vid_reg <= STARTUP_VID;
            mem_oe_reg <= 1'b0;
            cke_reg <= 1'b0;
            mrst_reg <= 1'b0;
            low_pwr_reg <= 1'b1;
            core_en_reg <= 1'b0;
            clk_stop_reg <= 1'b0;
            hot_oe_reg <= 1'b0;
        end else begin
            // Only the startup code is driven here; later codes belong to P-state logic.
            vid_reg <= STARTUP_VID;
            mem_oe_reg <= power_good_in;
            cke_reg <= run_ok;
            mrst_reg <= run_ok;
            low_pwr_reg <= ~chip_reset_n;
            clk_stop_reg <= trip_next;
            core_en_reg <= run_ok & ~trip_next & ~(throttle_next & thr_down);
            hot_oe_reg <= throttle_next;
        end
    end

    // Northbridge grid is never throttled and never held off, not even during reset.
    assign nb_clock_grid_en = 1'b1;
    assign hot_pin_n_out = 1'b0;
    assign hot_pin_n_oe = hot_oe_reg;
    assign thermtrip_n = ~trip_latch_reg;
    assign internal_clk_stop = clk_stop_reg;
    assign core_low_power = low_pwr_reg;
    assign core_clock_grid_en = core_en_reg;
    assign mem_pins_oe = mem_oe_reg;
    assign mem_cke = cke_reg;
    assign mem_reset_n = mrst_reg;
    assign mem_clk_oe = mem_clk_on_reg;
    assign mem_clk_p = mem_clk_reg;
    assign mem_clk_n = ~mem_clk_reg;
    assign voltage_select_code = vid_reg;
    assign lvt_thermal_irq = irq_reg;
    assign stc_bus_cycle = stc_cyc_reg;
    assign htc_enter_cycle = enter_cyc_reg;
    assign htc_exit_cycle = exit_cyc_reg;
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
endmodule
`default_nettype wire

/* File: dv/tpg_monitor.sv */
// Concurrent checks on the thermal power guard ports.
`timescale 1ns/1ns
`default_nettype none
module tpg_monitor
    import tpg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic power_good_in,
    input wire logic chip_reset_n,
    input wire logic hot_pin_n_out,
    input wire logic hot_pin_n_oe,
    input wire logic thermtrip_n,
    input wire logic internal_clk_stop,
    input wire logic core_low_power,
    input wire logic core_clock_grid_en,
    input wire logic nb_clock_grid_en,
    input wire logic mem_pins_oe,
    input wire logic mem_cke,
    input wire logic mem_reset_n,
    input wire logic [5:0] voltage_select_code
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Length of the current throttled down phase, in cycles.
    logic [9:0] down_cnt_reg;
    // Counts only while throttling in normal operation, so trip and reset stops are excluded.
    always_ff @(posedge clk) begin
        if (!rst_n || core_clock_grid_en || !hot_pin_n_oe || !thermtrip_n) begin
            down_cnt_reg <= 10'h000;
        end else if (power_good_in && chip_reset_n) begin
            down_cnt_reg <= down_cnt_reg + 10'h001;
        end
    end
    // Three cycles without power good or with chip reset held.
    sequence s_not_run;
        (!power_good_in || !chip_reset_n)[*3];
    endsequence
    a_mem_parked: assert property (!power_good_in |=> !mem_pins_oe && !mem_cke && !mem_reset_n)
        else $error("memory pins not parked without power good");
    a_vid_startup: assert property (!power_good_in |=> voltage_select_code == STARTUP_VID)
        else $error("voltage code not at startup level");
    a_reset_parks: assert property (!chip_reset_n |=> core_low_power && !mem_cke && !mem_reset_n)
        else $error("chip reset did not park core and memory");
    a_no_throttle_off: assert property (s_not_run |=> !hot_pin_n_oe)
        else $error("throttling while not running");
    a_down_bound: assert property (down_cnt_reg <= THROTTLE_DOWN_CYC)
        else $error("down phase too long");
    a_down_exact: assert property ($rose(core_clock_grid_en) && hot_pin_n_oe && $past(hot_pin_n_oe)
        |-> down_cnt_reg == THROTTLE_DOWN_CYC)
        else $error("down phase length wrong");
    a_nb_running: assert property (hot_pin_n_oe |-> nb_clock_grid_en)
        else $error("northbridge clock stopped while throttling");
    a_hot_drive: assert property (hot_pin_n_oe |-> !hot_pin_n_out)
        else $error("hot pin driven high");
    a_trip_stop: assert property (!thermtrip_n |-> internal_clk_stop && !core_clock_grid_en)
        else $error("clocks running during trip");
    a_trip_hold: assert property (!thermtrip_n && chip_reset_n |=> !thermtrip_n)
        else $error("trip released without chip reset");
endmodule
`default_nettype wire

/* File: dv/tpg_board.sv */
// Board power sequencing model that drops power good on a thermal trip.
`timescale 1ns/1ns
`default_nettype none
module tpg_board (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic thermtrip_n,
    input wire logic pg_want,
    input wire logic reset_want_n,
    output logic power_good_in,
    output logic chip_reset_n
);
    // Set once a trip is seen; only a chip reset pulse lets power good return.
    logic trip_seen_reg;
    // Remembers the trip so power good stays down after the output recovers.
    always_ff @(posedge clk) begin
        if (!rst_n || !reset_want_n) begin
            trip_seen_reg <= 1'b0;
        end else if (!thermtrip_n) begin
            trip_seen_reg <= 1'b1;
        end
    end
    assign power_good_in = pg_want && !trip_seen_reg && thermtrip_n;
    assign chip_reset_n = reset_want_n;
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench of the thermal power guard.
`timescale 1ns/1ns
`default_nettype none
module tb;
    import tpg_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic pg_want = 1'b1;
    logic reset_want_n = 1'b1;
    logic c3_state_in = 1'b0;
    logic hot_ext_n = 1'b1;
    logic [7:0] sensor_a_temp = 8'h20;
    logic [7:0] sensor_b_temp = 8'h10;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic [11:0] s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic power_good_in, chip_reset_n, hot_pin_n_out, hot_pin_n_oe, thermtrip_n;
    logic internal_clk_stop, core_low_power, core_clock_grid_en, nb_clock_grid_en;
    logic mem_pins_oe, mem_cke, mem_reset_n, mem_clk_oe, mem_clk_p, mem_clk_n;
    logic [5:0] voltage_select_code;
    logic lvt_thermal_irq, stc_bus_cycle, htc_enter_cycle, htc_exit_cycle;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    wire logic hot_pin_n_in;
    int bad_count = 0;
    int n_compared = 0;
    int enter_n = 0, exit_n = 0, lvt_n = 0, stc_n = 0, c;
    always #5 clk = ~clk;
    // The hot pin is pulled up; either side may pull it low.
    assign hot_pin_n_in = hot_pin_n_oe ? hot_pin_n_out : hot_ext_n;
    tpg_top DUT (.*);
    tpg_board u_board (.clk(clk), .rst_n(rst_n), .thermtrip_n(thermtrip_n), .pg_want(pg_want),
        .reset_want_n(reset_want_n), .power_good_in(power_good_in), .chip_reset_n(chip_reset_n));
    // One-cycle event pulses are counted here so no test has to catch them in flight.
    always @(posedge clk) begin
        enter_n <= enter_n + int'(htc_enter_cycle === 1'b1);
        exit_n <= exit_n + int'(htc_exit_cycle === 1'b1);
        lvt_n <= lvt_n + int'(lvt_thermal_irq === 1'b1);
        stc_n <= stc_n + int'(stc_bus_cycle === 1'b1);
    end
    task conclude;
        $display("Counts: compared %0d, bad %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task hang;
        bad_count++;
        $display("BAD wait expected 1 seen 0");
        conclude();
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Waits for a chosen output to reach a level; returns the cycles spent.
    task await(input int k, input logic v, input int n, output int cnt);
        logic [2:0] s;
        for (cnt = 0; cnt < n; cnt++) begin
            s = {thermtrip_n, core_clock_grid_en, hot_pin_n_oe};
            if (s[k] === v) break;
            tick(1);
        end
        if (cnt == n) hang();
    endtask
    // One AXI4-Lite write; address and data are released as each is taken.
    task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int i;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (i == 50) hang();
        chk("bresp", er, s_axi_bresp);
        s_axi_bready <= 1'b0;
    endtask
    // One AXI4-Lite read; the data word is compared only when an OKAY answer is expected.
    task rchk(input logic [11:0] a, input logic [1:0] er, input logic [31:0] e);
        int i;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (i == 50) hang();
        chk("rresp", er, s_axi_rresp);
        if (er == RESP_OKAY) chk("rdata", e, s_axi_rdata);
        s_axi_rready <= 1'b0;
    endtask
    initial begin
        tick(10);
        rst_n <= 1'b1;
        rchk(ADDR_CTRL, RESP_OKAY, CTRL_RESET);
        rchk(ADDR_TRIP, RESP_OKAY, TRIP_RESET);
        rchk(12'h010, RESP_SLVERR, 32'h0);
        wr(ADDR_STATUS, 32'hffff_ffff, RESP_SLVERR);
        wr(12'h010, 32'h0, RESP_SLVERR);
        wr(ADDR_THRESH, 32'h3040_0550, RESP_OKAY);
        rchk(ADDR_THRESH, RESP_OKAY, 32'h3040_0550);
        tick(1);
        chk("mem_clk_oe", 0, mem_clk_oe);
        wr(ADDR_CTRL, 32'h0000_0014, RESP_OKAY);
        tick(3);
        chk("mem_clk_oe", 1, mem_clk_oe);
        $display("registers done");
        pg_want <= 1'b0;
        tick(2);
        chk("parked", 32'h0000_0012, {mem_pins_oe, mem_cke, mem_reset_n, voltage_select_code});
        pg_want <= 1'b1;
        reset_want_n <= 1'b0;
        tick(2);
        chk("in_reset", 3'b110, {mem_pins_oe, core_low_power, mem_cke});
        reset_want_n <= 1'b1;
        tick(2);
        chk("run", 3'b011, {core_low_power, mem_cke, mem_reset_n});
        $display("power and reset done");
        sensor_b_temp <= 8'h60;
        await(0, 1'b1, 20, c);
        await(1, 1'b0, 5, c);
        await(1, 1'b1, 700, c);
        await(1, 1'b0, 400, c);
        chk("up_phase", THROTTLE_PERIOD_CYC - THROTTLE_DOWN_CYC, c);
        await(1, 1'b1, 400, c);
        chk("down_phase", THROTTLE_DOWN_CYC, c);
        sensor_b_temp <= 8'h4c;
        tick(20);
        chk("hyst_hold", 1, hot_pin_n_oe);
        sensor_b_temp <= 8'h4a;
        await(0, 1'b0, 20, c);
        tick(2);
        chk("enter_exit", {16'd1, 16'd1}, {enter_n[15:0], exit_n[15:0]});
        c3_state_in <= 1'b1;
        sensor_b_temp <= 8'h60;
        tick(20);
        chk("c3_block", 0, hot_pin_n_oe);
        c3_state_in <= 1'b0;
        await(0, 1'b1, 20, c);
        pg_want <= 1'b0;
        tick(5);
        pg_want <= 1'b1;
        sensor_b_temp <= 8'h10;
        await(0, 1'b0, 20, c);
        $display("temperature throttling done");
        wr(ADDR_CTRL, 32'h0000_0011, RESP_OKAY);
        hot_ext_n <= 1'b0;
        @(posedge clk) hot_ext_n <= 1'b1;
        tick(10);
        chk("glitch", 0, hot_pin_n_oe);
        hot_ext_n <= 1'b0;
        await(0, 1'b1, 20, c);
        hot_ext_n <= 1'b1;
        await(0, 1'b0, 20, c);
        wr(ADDR_CTRL, 32'h0000_0010, RESP_OKAY);
        hot_ext_n <= 1'b0;
        tick(20);
        chk("hot_off", 0, hot_pin_n_oe);
        hot_ext_n <= 1'b1;
        $display("hot pin done");
        wr(ADDR_CTRL, 32'h0000_0018, RESP_OKAY);
        sensor_a_temp <= 8'h45;
        tick(5);
        sensor_a_temp <= 8'h20;
        wr(ADDR_CTRL, 32'h0000_001a, RESP_OKAY);
        sensor_a_temp <= 8'h45;
        tick(5);
        sensor_a_temp <= 8'h20;
        tick(5);
        chk("irq_counts", {16'd2, 16'd2}, {lvt_n[15:0], stc_n[15:0]});
        $display("interrupts done");
        wr(ADDR_TRIP, 32'h0000_0070, RESP_OKAY);
        sensor_b_temp <= 8'h80;
        await(2, 1'b0, 20, c);
        tick(2);
        chk("pg_drop", 0, power_good_in);
        reset_want_n <= 1'b0;
        tick(3);
        chk("trip_clear", 1, thermtrip_n);
        reset_want_n <= 1'b1;
        await(2, 1'b0, 10, c);
        sensor_b_temp <= 8'h10;
        tick(10);
        chk("trip_latch", 0, thermtrip_n);
        reset_want_n <= 1'b0;
        tick(3);
        reset_want_n <= 1'b1;
        tick(5);
        chk("recover", 2'b11, {thermtrip_n, power_good_in});
        $display("thermal trip done");
        conclude();
    end
endmodule
bind tpg_top tpg_monitor u_mon (.*);
`default_nettype wire
